// ---- logic/csm_pkg.sv ----
package csm_pkg;
  typedef enum logic [1:0] {
    CSM_OP_SINGLE,
    CSM_OP_TX,
    CSM_OP_RX,
    CSM_OP_TXRX
  } csm_op_t;

  typedef struct packed {
    csm_op_t op;
    logic slave;
    logic [7:0] command;
    logic [5:0] count;
  } csm_req_t;

  localparam int CSM_CLK_MHZ = 100;
  localparam int CSM_TIMEOUT_US = 10;
  localparam int CSM_TIMEOUT_CYC = CSM_TIMEOUT_US * CSM_CLK_MHZ;
  localparam int CSM_BIT_NS = 1000;
  localparam int CSM_HALF_CYC = CSM_BIT_NS / 2 / (1000 / CSM_CLK_MHZ);
  localparam int CSM_DATA_BITS = 8;
  localparam logic [1:0] CSM_SEL_IDLE = 2'h3;
endpackage : csm_pkg

// ---- logic/csm_buf2.sv ----
`timescale 1ns/1ns
module csm_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] cnt_r, cnt_nxt;
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : inc

  always_comb begin
    push = in_valid_in && (cnt_r != (AW+1)'(DEPTH));
    pop = out_ready_in && (cnt_r != '0);
    wp_nxt = push ? inc(wp_r) : wp_r;
    rp_nxt = pop ? inc(rp_r) : rp_r;
    cnt_nxt = cnt_r + (push ? (AW+1)'(1) : '0) - (pop ? (AW+1)'(1) : '0);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cnt_r <= '0;
      wp_r <= '0;
      rp_r <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      in_ready_out <= (cnt_nxt != (AW+1)'(DEPTH));
      out_valid_out <= (cnt_nxt != '0);
      out_data_out <= (pop || cnt_r == '0) && push && cnt_nxt == (AW+1)'(1) ? in_data_in :
                      mem_r[rp_nxt];
    end
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
endmodule : csm_buf2

// ---- logic/csm_master.sv ----
`timescale 1ns/1ns
module csm_master #(
  parameter int TIMEOUT_CYC = csm_pkg::CSM_TIMEOUT_CYC,
  parameter int HALF_CYC = csm_pkg::CSM_HALF_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic req_valid_in,
  input wire csm_pkg::csm_req_t req_in,
  output logic req_ready_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in,
  output logic done_out,
  output logic timeout_out,
  output logic [1:0] sel_n_out,
  output logic sck_out,
  output logic sdo_out,
  input wire logic sdi_in,
  input wire logic busy_in
);
  typedef enum logic [2:0] {
    CSM_IDLE,
    CSM_WAIT_CMD,
    CSM_SHIFT,
    CSM_WAIT_DATA,
    CSM_LOAD,
    CSM_STALL,
    CSM_END
  } csm_state_t;

  csm_state_t st_r, st_nxt;
  csm_pkg::csm_req_t req_r, req_nxt;
  logic [1:0] sel_n_r, sel_n_nxt;
  logic sck_r, sck_nxt, sdo_r, sdo_nxt, cmd_r, cmd_nxt;
  logic [7:0] sh_r, sh_nxt, rxw_r, rxw_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [5:0] left_r, left_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [15:0] half_r, half_nxt;
  logic done_nxt, tmo_nxt;
  logic rxv_nxt, tx_take;
  logic [1:0] busy_s_r, sdi_s_r;
  logic buf_ready;

  // Inbound pins pass two flops before any use
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      busy_s_r <= 2'h3;
      sdi_s_r <= 2'h0;
    end else begin
      busy_s_r <= {busy_s_r[0], busy_in};
      sdi_s_r <= {sdi_s_r[0], sdi_in};
    end
  end

  function automatic logic op_tx(input csm_pkg::csm_op_t o);
    op_tx = (o != csm_pkg::CSM_OP_RX);
  endfunction : op_tx

  function automatic logic last_char(input logic [5:0] n);
    last_char = (n == 6'h01);
  endfunction : last_char

  csm_buf2 #(.WIDTH(8), .DEPTH(2)) u_rxbuf (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(rxv_nxt),
    .in_ready_out(buf_ready),
    .in_data_in(rxw_r),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in),
    .out_data_out(rx_data_out)
  );

  always_comb begin
    st_nxt = st_r;
    req_nxt = req_r;
    sel_n_nxt = sel_n_r;
    sck_nxt = sck_r;
    sdo_nxt = sdo_r;
    cmd_nxt = cmd_r;
    sh_nxt = sh_r;
    rxw_nxt = rxw_r;
    bit_nxt = bit_r;
    left_nxt = left_r;
    tmr_nxt = tmr_r;
    half_nxt = half_r;
    done_nxt = 1'b0;
    tmo_nxt = 1'b0;
    rxv_nxt = 1'b0;
    tx_take = 1'b0;
    unique case (st_r)
      CSM_IDLE: begin
        if (req_valid_in) begin
          req_nxt = req_in;
          sel_n_nxt = req_in.slave ? 2'h1 : 2'h2;
          tmr_nxt = '0;
          cmd_nxt = 1'b1;
          sh_nxt = req_in.command;
          left_nxt = (req_in.op == csm_pkg::CSM_OP_SINGLE || req_in.count == '0) ? 6'h01 : req_in.count;
          st_nxt = CSM_WAIT_CMD;
        end
      end
      CSM_WAIT_CMD, CSM_WAIT_DATA: begin
        tmr_nxt = tmr_r + 16'h0001;
        if (!busy_s_r[1]) begin
          tmr_nxt = '0;
          st_nxt = (st_r == CSM_WAIT_CMD) ? CSM_SHIFT : CSM_LOAD;
          sdo_nxt = sh_r[7];
          bit_nxt = '0;
          half_nxt = '0;
        end else if (tmr_r >= 16'(TIMEOUT_CYC - 1)) begin
          tmo_nxt = 1'b1;
          st_nxt = CSM_END;
        end
      end
      CSM_LOAD: begin
        // Receive-only characters shift out all ones
        if (!op_tx(req_r.op)) begin
          sh_nxt = 8'hFF;
          sdo_nxt = 1'b1;
          bit_nxt = '0;
          half_nxt = '0;
          st_nxt = CSM_SHIFT;
        end else if (tx_valid_in) begin
          tx_take = 1'b1;
          sh_nxt = tx_data_in;
          sdo_nxt = tx_data_in[7];
          bit_nxt = '0;
          half_nxt = '0;
          st_nxt = CSM_SHIFT;
        end
      end
      CSM_SHIFT: begin
        half_nxt = half_r + 16'h0001;
        if (half_r >= 16'(HALF_CYC - 1)) begin
          half_nxt = '0;
          sck_nxt = ~sck_r;
          if (!sck_r) begin
            rxw_nxt = {rxw_r[6:0], sdi_s_r[1]};
          end else begin
            sh_nxt = {sh_r[6:0], 1'b0};
            sdo_nxt = sh_r[6];
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'(csm_pkg::CSM_DATA_BITS - 1)) begin
              sdo_nxt = 1'b1;
              if (cmd_r) begin
                cmd_nxt = 1'b0;
                st_nxt = CSM_WAIT_DATA;
              end else if (req_r.op != csm_pkg::CSM_OP_TX) begin
                st_nxt = CSM_STALL;
              end else begin
                left_nxt = left_r - 6'h01;
                st_nxt = last_char(left_r) ? CSM_END : CSM_LOAD;
                done_nxt = last_char(left_r);
              end
            end
          end
        end
      end
      CSM_STALL: begin
        // Clock stays still while the receive buffer is full
        if (buf_ready) begin
          rxv_nxt = 1'b1;
          left_nxt = left_r - 6'h01;
          st_nxt = last_char(left_r) ? CSM_END : CSM_LOAD;
          done_nxt = last_char(left_r);
        end
      end
      CSM_END: begin
        sel_n_nxt = csm_pkg::CSM_SEL_IDLE;
        st_nxt = CSM_IDLE;
      end
      default: st_nxt = CSM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st_r <= CSM_IDLE;
      req_r <= '0;
      sel_n_r <= csm_pkg::CSM_SEL_IDLE;
      sck_r <= 1'b0;
      sdo_r <= 1'b1;
      cmd_r <= 1'b0;
      sh_r <= '0;
      rxw_r <= '0;
      bit_r <= '0;
      left_r <= '0;
      tmr_r <= '0;
      half_r <= '0;
      done_out <= 1'b0;
      timeout_out <= 1'b0;
      req_ready_out <= 1'b0;
      tx_ready_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
      req_r <= req_nxt;
      sel_n_r <= sel_n_nxt;
      sck_r <= sck_nxt;
      sdo_r <= sdo_nxt;
      cmd_r <= cmd_nxt;
      sh_r <= sh_nxt;
      rxw_r <= rxw_nxt;
      bit_r <= bit_nxt;
      left_r <= left_nxt;
      tmr_r <= tmr_nxt;
      half_r <= half_nxt;
      done_out <= done_nxt;
      timeout_out <= tmo_nxt;
      req_ready_out <= (st_nxt == CSM_IDLE);
      tx_ready_out <= (st_nxt == CSM_LOAD) && op_tx(req_nxt.op) && !tx_take;
    end
  end

  assign sel_n_out = sel_n_r;
  assign sck_out = sck_r;
  assign sdo_out = sdo_r;
endmodule : csm_master

// ---- verification/csm_master_monitor.sv ----
`timescale 1ns/1ns
module csm_master_monitor #(parameter int TIMEOUT_CYC = 40, parameter int HALF_CYC = 4) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic done_out,
  input wire logic timeout_out,
  input wire logic [1:0] sel_n_out,
  input wire logic sck_out,
  input wire logic busy_in
);
  int hi_r;
  int hold_r;
  logic sck_r;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // Busy-high run while selected, and length of the current clock level
  always_ff @(posedge ref_clk_in) begin
    hi_r <= (&sel_n_out || !busy_in) ? 0 : hi_r + 1;
    hold_r <= (sck_out != sck_r) ? 0 : hold_r + 1;
    sck_r <= sck_out;
  end
  property p_one; sel_n_out != 2'h0; endproperty
  a_one: assert property (p_one) else $error("both selects low");
  property p_take; req_valid_in && req_ready_out |=> ##[0:1] sel_n_out != 2'h3; endproperty
  a_take: assert property (p_take) else $error("no select");
  property p_sck; sck_out |-> sel_n_out != 2'h3; endproperty
  a_sck: assert property (p_sck) else $error("clock unselected");
  property p_wait; busy_in && $past(busy_in) && $past(busy_in, 2) && $past(busy_in, 3) && !sck_out |=> !sck_out;
  endproperty
  a_wait: assert property (p_wait) else $error("clock while busy");
  property p_half; $fell(sck_out) |-> hold_r == HALF_CYC - 1; endproperty
  a_half: assert property (p_half) else $error("clock high time");
  property p_tmo; timeout_out |-> hi_r inside {[TIMEOUT_CYC - 2:TIMEOUT_CYC + 4]}; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout moment");
  property p_abort; timeout_out |-> ##[0:2] &sel_n_out; endproperty
  a_abort: assert property (p_abort) else $error("select kept");
  property p_done; done_out |-> ##[0:2] &sel_n_out; endproperty
  a_done: assert property (p_done) else $error("select after end");
  c_done: cover property (done_out);
  c_tmo: cover property (timeout_out);
  c_sck: cover property ($rose(sck_out));
endmodule : csm_master_monitor
bind csm_master csm_master_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC), .HALF_CYC(HALF_CYC)) u_mon (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
  .done_out(done_out), .timeout_out(timeout_out), .sel_n_out(sel_n_out), .sck_out(sck_out), .busy_in(busy_in));

// ---- verification/csm_slave_model.sv ----
`timescale 1ns/1ns
module csm_slave_model #(parameter int DELAY = 6, parameter logic [7:0] PAT = 8'hA5) (
  input wire logic ref_clk_in,
  input wire logic sel_n_in,
  input wire logic absent_in,
  input wire logic sck_in,
  input wire logic sdo_in,
  output logic busy_out,
  output logic sdi_out,
  output logic [7:0] got_out
);
  int wait_r = 0;
  int bits_r = 0;
  logic [2:0] idx_r = 3'h7;
  // Ready after DELAY cycles, busy again for DELAY cycles after the command
  always @(posedge ref_clk_in) begin
    if (sel_n_in) wait_r <= 0;
    else if (wait_r < DELAY || (bits_r == 8 && wait_r < 2 * DELAY)) wait_r <= wait_r + 1;
  end
  assign busy_out = sel_n_in | absent_in | (wait_r < DELAY) | (bits_r == 8 && wait_r < 2 * DELAY);
  always @(posedge sck_in or posedge sel_n_in) begin
    if (sel_n_in) bits_r <= 0;
    else bits_r <= bits_r + 1;
    if (!sel_n_in) got_out <= {got_out[6:0], sdo_in};
  end
  always @(negedge sck_in or posedge sel_n_in) begin
    if (sel_n_in) idx_r <= 3'h7;
    else idx_r <= idx_r - 3'h1;
  end
  // Unselected line shows the inverse of the pending bit
  assign sdi_out = sel_n_in ? ~PAT[idx_r] : PAT[idx_r];
endmodule : csm_slave_model

// ---- verification/csi_master_busy_handshake_bench.sv ----
`timescale 1ns/1ns
module csi_master_busy_handshake_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rv = 1'b0;
  logic rxr = 1'b1;
  logic absent = 1'b0;
  logic txv = 1'b1;
  logic [7:0] txd = 8'h00;
  logic [7:0] pat = 8'hA5;
  csm_pkg::csm_req_t rq = '0;
  logic rr, txr, rxv, done, tmo, sck, sdo, b0, b1, s0, s1;
  logic [7:0] rxd, g0, g1;
  logic [1:0] sel_n;
  int err_count = 0;
  int checks = 0;
  int nrx = 0;
  csm_master #(.TIMEOUT_CYC(40), .HALF_CYC(4)) dut (.ref_clk_in(clk), .rstn_in(rstn), .req_valid_in(rv),
    .req_in(rq), .req_ready_out(rr), .tx_valid_in(txv), .tx_data_in(txd), .tx_ready_out(txr),
    .rx_valid_out(rxv), .rx_data_out(rxd), .rx_ready_in(rxr), .done_out(done), .timeout_out(tmo),
    .sel_n_out(sel_n), .sck_out(sck), .sdo_out(sdo), .sdi_in(sel_n[0] ? s1 : s0), .busy_in(b0 & b1));
  csm_slave_model #(.PAT(8'hA5)) m0 (.ref_clk_in(clk), .sel_n_in(sel_n[0]), .absent_in(1'b0), .sck_in(sck),
    .sdo_in(sdo), .busy_out(b0), .sdi_out(s0), .got_out(g0));
  csm_slave_model #(.PAT(8'h3C)) m1 (.ref_clk_in(clk), .sel_n_in(sel_n[1]), .absent_in(absent), .sck_in(sck),
    .sdo_in(sdo), .busy_out(b1), .sdi_out(s1), .got_out(g1));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  always @(posedge clk) begin
    if (rxv === 1'b1 && rxr) begin
      nrx <= nrx + 1;
      chk(rxd === pat, "rx word");
    end
  end
  task automatic run(input int op, input int s, input int n, input int stall, input int txhold, output int t,
                     output logic to);
    @(negedge clk);
    chk(rr === 1'b1 && sel_n === 2'h3 && txr === 1'b0, "idle state");
    @(posedge clk);
    rq <= '{csm_pkg::csm_op_t'(op[1:0]), s[0], 8'hC3, n[5:0]};
    txd <= 8'h50 + 8'(op);
    txv <= (txhold == 0);
    pat <= s[0] ? 8'h3C : 8'hA5;
    rxr <= (stall == 0);
    nrx = 0;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    repeat (stall) @(posedge clk);
    rxr <= 1'b1;
    t = 0;
    while (txhold > 0 && txr !== 1'b1 && t < 400) begin
      @(negedge clk);
      t++;
    end
    if (txhold > 0) begin
      repeat (txhold) @(negedge clk);
      chk(txr === 1'b1 && sck === 1'b0 && done === 1'b0, "tx word wait");
      @(posedge clk);
      txv <= 1'b1;
    end
    t = 0;
    while (done !== 1'b1 && tmo !== 1'b1 && t < 9000) begin
      @(negedge clk);
      t++;
    end
    chk(t < 9000, "run limit");
    to = tmo;
    repeat (6) @(posedge clk);
  endtask : run
  task automatic t_ops;
    int t;
    logic to;
    for (int op = 0; op < 4; op++) begin
      run(op, op % 2, 3, 0, op == 1 ? 20 : 0, t, to);
      chk(to === 1'b0 && nrx == (op == 1 ? 0 : (op == 0 ? 1 : 3)), "op count");
      chk((op % 2 ? g1 : g0) === (op == 2 ? 8'hFF : 8'h50 + 8'(op)), "slave byte");
    end
  endtask : t_ops
  task automatic t_stall;
    int t;
    logic to;
    run(3, 0, 63, 600, 0, t, to);
    chk(to === 1'b0 && nrx == 63 && g0 === 8'h53, "stalled burst");
  endtask : t_stall
  task automatic t_absent;
    int t;
    logic to;
    absent <= 1'b1;
    run(2, 1, 2, 0, 0, t, to);
    chk(to === 1'b1 && t >= 38 && t <= 50 && nrx == 0, "timeout");
    chk(sel_n === 2'h3, "select held");
    absent <= 1'b0;
    run(0, 1, 0, 0, 0, t, to);
    chk(to === 1'b0 && nrx == 1 && g1 === 8'h50, "recovery");
  endtask : t_absent
  task final_report;
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_ops();
    t_stall();
    t_absent();
    final_report();
  end
  initial begin
    #400000;
    err_count++;
    final_report();
  end
endmodule : csi_master_busy_handshake_bench
